// [hw/rcod_defines.svh]
// Notes on behaviour
// - Sleep-run bit keeps output toggling in Sleep
// - Source bit: 1 crystal, 0 system clock
// - Divide field gives ratio two to field, except field zero on system clock divides by two
// - Bit 14 and low byte read zero
// - Output goes to the pin-select fabric
`ifndef RCOD_DEFINES_SVH
`define RCOD_DEFINES_SVH

`define RCOD_CTRL_OFFS    4'h0
`define RCOD_CTRL_RESET   16'h0000
`define RCOD_CTRL_WMASK   16'hBF00
`define RCOD_BIT_ENABLE   15
`define RCOD_BIT_SLEEPRUN 13
`define RCOD_BIT_SOURCE   12
`define RCOD_DIV_MSB      11
`define RCOD_DIV_LSB      8
`define RCOD_DIV_W        4
`define RCOD_CNT_W        15

`endif

// [hw/rcod_pkg.sv]
`include "rcod_defines.svh"

package rcod_pkg;

	typedef enum logic [1:0] {
		RCOD_BUS_IDLE = 2'b01,
		RCOD_BUS_ACK  = 2'b10
	} rcod_bus_e;

	typedef logic [`RCOD_DIV_W-1:0] rcod_div_t;
	typedef logic [`RCOD_CNT_W-1:0] rcod_cnt_t;

	typedef struct packed {
		rcod_cnt_t count;
		logic      clkOut;
	} rcod_div_s;

	typedef struct packed {
		rcod_bus_e   busState;
		logic        waitReq;
		logic [31:0] readData;
		logic [15:0] ctrl;
		rcod_div_t   activeDiv;
		logic        xtalS1;
		logic        xtalS2;
		logic        xtalS3;
		logic        xtalLvl;
		logic        xtalTick;
		logic        active;
	} rcod_top_s;

endpackage

// [hw/rcod_divider.sv]
module rcod_divider #(
	parameter int DIV_W = 4,
	parameter int CNT_W = 15
) (
	// Clock and reset
	input  wire logic             mclk,
	input  wire logic             rstn,
	// Control
	input  wire logic             run,
	input  wire logic             tick,
	input  wire logic [DIV_W-1:0] divSel,
	input  wire logic             bypass,
	input  wire logic             bypassLvl,
	// Divided clock
	output      logic             clkOut
);
	import rcod_pkg::*;

	// Refuse widths the counter cannot serve
	if (DIV_W < 1 || CNT_W < (1 << DIV_W) - 2 || CNT_W > 31) begin : g_bad_width
		$error("rcod_divider: counter too narrow for divide field");
	end

	rcod_div_s st_ff;
	rcod_div_s nxt_st;
	logic [CNT_W-1:0] limit;

	always_comb begin
		nxt_st = st_ff;
		// Half period two to field minus one
		if (divSel == '0) begin
			limit = '0;
		end else begin
			limit = CNT_W'((CNT_W'(1) << (divSel - DIV_W'(1))) - CNT_W'(1));
		end
		if (!run) begin
			nxt_st.count  = '0;
			nxt_st.clkOut = 1'b0;
		end else if (bypass) begin
			nxt_st.count  = '0;
			nxt_st.clkOut = bypassLvl;
		end else if (tick) begin
			if (st_ff.count >= limit) begin
				nxt_st.count  = '0;
				nxt_st.clkOut = ~st_ff.clkOut;
			end else begin
				nxt_st.count = st_ff.count + CNT_W'(1);
			end
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign clkOut = st_ff.clkOut;
endmodule

// [hw/rcod_top.sv]
`include "rcod_defines.svh"

module rcod_top (
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        rstn,
	// Avalon-MM slave
	input  wire logic [3:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	input  wire logic [3:0]  byteenable,
	output      logic [31:0] readdata,
	output      logic        waitrequest,
	// System status and crystal pin
	input  wire logic        sleepMode,
	input  wire logic        xtalPin,
	// Peripheral output function to pin-select fabric
	output      logic        refclkOut,
	output      logic        refclkActive
);
	import rcod_pkg::*;

	rcod_top_s st_ff;
	rcod_top_s nxt_st;
	logic      ctrlHit;
	logic      useXtal;
	logic      runNow;
	logic      srcTick;
	logic      divOut;

	always_comb begin
		nxt_st  = st_ff;
		ctrlHit = (address == `RCOD_CTRL_OFFS);
		useXtal = st_ff.ctrl[`RCOD_BIT_SOURCE];
		// Crystal pin synchroniser and agreement filter
		nxt_st.xtalS1 = xtalPin;
		nxt_st.xtalS2 = st_ff.xtalS1;
		nxt_st.xtalS3 = st_ff.xtalS2;
		if (st_ff.xtalS2 == st_ff.xtalS3) begin
			nxt_st.xtalLvl = st_ff.xtalS3;
		end
		nxt_st.xtalTick = nxt_st.xtalLvl & ~st_ff.xtalLvl;
		// Sleep gates output unless sleep-run set
		runNow = st_ff.ctrl[`RCOD_BIT_ENABLE]
			& (~sleepMode | st_ff.ctrl[`RCOD_BIT_SLEEPRUN]);
		nxt_st.active = runNow;
		// Ratio taken only while output disabled
		if (!st_ff.ctrl[`RCOD_BIT_ENABLE]) begin
			nxt_st.activeDiv = st_ff.ctrl[`RCOD_DIV_MSB:`RCOD_DIV_LSB];
		end
		// Bus slave: one wait cycle then acknowledge
		case (st_ff.busState)
			RCOD_BUS_IDLE: begin
				nxt_st.waitReq = 1'b1;
				if (read || write) begin
					nxt_st.busState = RCOD_BUS_ACK;
					nxt_st.waitReq  = 1'b0;
					nxt_st.readData = ctrlHit ? {16'h0000, st_ff.ctrl & `RCOD_CTRL_WMASK}
						: 32'h0000_0000;
				end
			end
			RCOD_BUS_ACK: begin
				nxt_st.busState = RCOD_BUS_IDLE;
				nxt_st.waitReq  = 1'b1;
				if (write && ctrlHit && byteenable[1]) begin
					nxt_st.ctrl = writedata[15:0] & `RCOD_CTRL_WMASK;
				end
			end
			default: begin
				nxt_st.busState = RCOD_BUS_IDLE;
				nxt_st.waitReq  = 1'b1;
			end
		endcase
	end

	// Source select: crystal ticks or every cycle
	assign srcTick = useXtal ? st_ff.xtalTick : 1'b1;

	rcod_divider #(
		.DIV_W (`RCOD_DIV_W),
		.CNT_W (`RCOD_CNT_W)
	) u_div (
		.mclk      (mclk),
		.rstn      (rstn),
		.run       (st_ff.active),
		.tick      (srcTick),
		.divSel    (st_ff.activeDiv),
		.bypass    (useXtal && st_ff.activeDiv == '0),
		.bypassLvl (st_ff.xtalLvl),
		.clkOut    (divOut)
	);

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			st_ff          <= '0;
			st_ff.busState <= RCOD_BUS_IDLE;
			st_ff.waitReq  <= 1'b1;
			st_ff.ctrl     <= `RCOD_CTRL_RESET;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign readdata     = st_ff.readData;
	assign waitrequest  = st_ff.waitReq;
	// Output and its drive request to pin-select
	assign refclkOut    = divOut;
	assign refclkActive = st_ff.active;
endmodule

// [test/rcod_xtal_model.sv]
module rcod_xtal_model #(
	parameter int HALF_NS = 73
) (
	// Crystal
	output logic xtalPin
);
	timeunit 1ns;
	timeprecision 1ns;
	initial xtalPin = 1'h0;
	always #(HALF_NS) xtalPin = ~xtalPin;
endmodule

// [test/rcod_top_monitor.sv]
module rcod_top_monitor (
	// Bus
	input wire logic        mclk,
	input wire logic        rstn,
	input wire logic [3:0]  address,
	input wire logic        read,
	input wire logic        write,
	input wire logic [31:0] writedata,
	input wire logic [3:0]  byteenable,
	input wire logic [31:0] readdata,
	input wire logic        waitrequest,
	// Pin
	input wire logic        sleepMode,
	input wire logic        refclkOut,
	input wire logic        refclkActive
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] c;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn);
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			c <= 8'h00;
		else if (write && !waitrequest && address==4'h0 && byteenable[1])
			c <= writedata[15:8] & 8'hBF;
	end
	sequence s_run; refclkActive [*4]; endsequence
	property p_slp; refclkActive==$past(c[7] && (!sleepMode || c[5])); endproperty
	a_slp: assert property (p_slp) else $error("act");
	property p_rd; read && !waitrequest |-> readdata==({16'h0,c,8'h0} & {32{address==4'h0}}); endproperty
	a_rd: assert property (p_rd) else $error("rd");
	property p_off; !refclkActive [*2] |-> !refclkOut; endproperty
	a_off: assert property (p_off) else $error("off");
	property p_div; s_run ##0 c[4:0]==5'h01 |-> $changed(refclkOut); endproperty
	a_div: assert property (p_div) else $error("div");
	property p_src; c[4] && $changed(refclkOut) |=> $stable(refclkOut) || !refclkActive; endproperty
	a_src: assert property (p_src) else $error("src");
	property p_pin; $rose(refclkOut) |-> refclkActive || $past(refclkActive); endproperty
	a_pin: assert property (p_pin) else $error("pin");
endmodule
bind rcod_top rcod_top_monitor i_mon (.mclk, .rstn, .address, .read, .write, .writedata,
	.byteenable, .readdata, .waitrequest, .sleepMode, .refclkOut, .refclkActive);

// [test/test_reference_clock_output_divider.sv]
module test_reference_clock_output_divider;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk=1'h0, rstn=1'h0, read=1'h0, write=1'h0, sleepMode=1'h0, r;
	logic waitrequest, refclkOut, refclkActive, xtalPin;
	logic [3:0] address=4'h0, byteenable=4'h0, n, p;
	logic [31:0] writedata=32'h0, readdata, q[$];
	int num_errors=0, cmp_count=0, seed=34198;
	time t;
	localparam int XTAL_NS = 146;
	always #10 mclk = ~mclk;
	rcod_top i_dut (.mclk, .rstn, .address, .read, .write, .writedata, .byteenable,
		.readdata, .waitrequest, .sleepMode, .xtalPin, .refclkOut, .refclkActive);
	rcod_xtal_model #(.HALF_NS (XTAL_NS / 2)) i_xtal (.xtalPin);
	task chk(input string s, input logic [31:0] v, x);
		cmp_count++;
		if (v !== x) begin
			num_errors++;
			$display("[FAIL] %s exp %h got %h", s, x, v);
		end
	endtask
	task final_report;
		if (num_errors==0 && cmp_count>0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task acc(input logic [3:0] a, input logic [15:0] d, input logic [3:0] b, input logic w);
		@(posedge mclk);
		{address, writedata, byteenable, write, read} <= {a, 16'h0, d, b, w, !w};
		do @(posedge mclk); while (waitrequest !== 1'h0);
		{write, read} <= 2'h0;
	endtask
	task rd(input logic [3:0] a, input logic [31:0] x);
		q.push_back(x);
		acc(a, 16'h0, 4'hF, 1'h0);
	endtask
	always @(posedge mclk) begin
		if (read && waitrequest === 1'h0)
			chk("rd", readdata, q.pop_front());
	end
	initial begin
		repeat (10) @(posedge mclk);
		rstn <= 1'h1;
		rd(4'h0, 32'h0);
		rd(4'h7, 32'h0);
		acc(4'h0, 16'hFFFF, 4'hF, 1'h1);
		acc(4'h0, 16'h0, 4'hD, 1'h1);
		rd(4'h0, 32'hBF00);
		repeat (40) @(posedge mclk);
		p = 4'hF;
		for (int i = 0; i < 4; i++) begin
			n = (i == 0) ? 4'h1 : 4'($unsigned($random(seed)) % 4 + 1);
			r = 1'($random(seed));
			acc(4'h0, {4'h0, p, 8'h0}, 4'h2, 1'h1);
			acc(4'h0, {4'h0, n, 8'h0}, 4'h2, 1'h1);
			acc(4'h0, {2'h2, r, 1'h0, n, 8'h0}, 4'h2, 1'h1);
			p = n;
			@(posedge refclkOut) t = $time;
			@(posedge refclkOut) chk("per", 32'(($time-t)/20), 32'h1 << n);
			sleepMode <= 1'h1;
			repeat (3) @(posedge mclk);
			chk("act", 32'(refclkActive), 32'(r));
			chk("slp", 32'(refclkOut & ~r), 32'h0);
			sleepMode <= 1'h0;
		end
		acc(4'h0, {4'h0, p, 8'h0}, 4'h2, 1'h1);
		acc(4'h0, 16'h1300, 4'h2, 1'h1);
		acc(4'h0, 16'h9300, 4'h2, 1'h1);
		@(posedge refclkOut) t = $time;
		@(posedge refclkOut) chk("xper", 32'(($time-t+XTAL_NS/2)/XTAL_NS), 32'h8);
		rstn <= 1'h0;
		repeat (2) @(posedge mclk);
		chk("rst", 32'({refclkOut, refclkActive}), 32'h0);
		rstn <= 1'h1;
		rd(4'h0, 32'h0);
		final_report;
	end
	initial begin
		#100000;
		num_errors++;
		final_report;
	end
endmodule
